/* rtl/bfm_pkg.sv */
/*
 * Constants for the ball function multiplexer: register addresses, field
 * positions, per-ball reset words and per-ball mode tables.
 * Assumes a single 40 MHz clock domain and one register per ball.
 */
// Behaviour
// - Ball drives the function software selected.
// - Mode code sits in low four bits.
// - One control register per ball, memory mapped.
// - Mode zero selects the ball's named signal.
// - Power-on reset gives each ball listed state.
// - Software enables or disables each pull resistor.
// - Balls without listed pull have none.
// - Serial b input ball modes 0,1,2,6.
// - Serial b output ball modes 0,1,2.
// - Host interrupt ball modes 0,1,2,6.
// - Sync input ball modes 0,1,6,7,9.
// - Sync output ball samples strap bit 1.
// - Test clock ball modes 0,1,2,8.
// - Test data input ball modes 0,1,2.
// - Test data output samples strap bit 0.
// - Test mode ball modes 0,1,2,6.
// - Warm reset ball: mode 0, open drain.
// - Function select bits 3:0, reset one.
package bfm_pkg;
    localparam int NBALL = 10;          // balls handled here
    localparam int NMODE = 16;          // codes of a 4-bit field
    localparam int REG_W = 32;          // control register width
    localparam int MODE_W = 4;          // function select width
    // field positions of a ball control register
    localparam int FSEL_LSB = 0;
    localparam int FSEL_MSB = 3;
    localparam int IE_CTRL_BIT = 4;     // input override control
    localparam int IE_OVR_BIT = 5;      // forced input value
    localparam int OE_CTRL_BIT = 6;     // output override control
    localparam int OE_OVR_BIT = 7;      // 1 = output forced off
    localparam int PULL_DIS_BIT = 8;    // 1 = pull disabled
    localparam int PULL_UP_BIT = 9;     // 1 = up, 0 = down
    localparam logic [MODE_W-1:0] MODE_DEFAULT = 4'h0;
    localparam logic [MODE_W-1:0] FSEL_RST = 4'h1;
    // ball indices
    localparam int B_SERB_IN = 0;
    localparam int B_SERB_OUT = 1;
    localparam int B_HOST_INT = 2;
    localparam int B_SYNC_IN = 3;
    localparam int B_SYNC_OUT = 4;
    localparam int B_TEST_CLK = 5;
    localparam int B_TEST_DI = 6;
    localparam int B_TEST_DO = 7;
    localparam int B_TEST_MODE = 8;
    localparam int B_WARM_RST = 9;
    // ball_control_register addresses, main_subsystem map
    localparam logic [31:0] BALL_ADDR [NBALL] = '{
        32'hFFFFEA20, 32'hFFFFEA1C, 32'hFFFFEA00, 32'hFFFFEA6C,
        32'hFFFFEA70, 32'hFFFFEA50, 32'h0FFFEA58, 32'hFFFFEA5C,
        32'hFFFFEA54, 32'hFFFFEA48};
    // power-on words: fsel 1, output off except B_TEST_DO forced on, pull per ball
    localparam logic [REG_W-1:0] RST_VAL [NBALL] = '{
        32'h000002C1, 32'h000002C1, 32'h000000C1, 32'h000000C1,
        32'h000000C1, 32'h000000C1, 32'h000002C1, 32'h00000141,
        32'h000000C1, 32'h000001C1};
    // listed modes per ball, bit n = mode n
    localparam logic [NMODE-1:0] VALID_MASK [NBALL] = '{
        16'h0047, 16'h0007, 16'h0047, 16'h02C3, 16'h0E03,
        16'h0107, 16'h0007, 16'h02C7, 16'h0047, 16'h0001};
    // modes whose function may drive the ball
    localparam logic [NMODE-1:0] OUT_MASK [NBALL] = '{
        16'h0047, 16'h0007, 16'h0047, 16'h0241, 16'h0C03,
        16'h0105, 16'h0001, 16'h00C7, 16'h0005, 16'h0001};
    localparam logic [NBALL-1:0] HAS_PULL = 10'h17F;
    localparam logic [NBALL-1:0] OPEN_DRAIN = 10'h200;
endpackage

/* rtl/bfm_ball_if.sv */
/*
 * Carrier between the register side and one ball's routing logic.
 * Assumes one instance per ball, all on the block clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface bfm_ball_if;
    logic [bfm_pkg::REG_W-1:0] ctrl;    // control register word
    logic hold_off;                     // strap sampling, keep output off
    logic [bfm_pkg::NMODE-1:0] fn_out;  // function output per mode
    logic [bfm_pkg::NMODE-1:0] fn_oe;   // function enable per mode
    logic pad_in;                       // level seen on the ball
    logic pad_out;                      // level driven to the ball
    logic pad_oe;                       // ball driver enable
    logic pull_en;                      // pull resistor on
    logic pull_up;                      // pull direction
    logic fn_in;                        // input given to functions
    logic [bfm_pkg::NMODE-1:0] fn_sel;  // one-hot selected function
    modport ctl(output ctrl, hold_off, fn_out, fn_oe, pad_in,
        input pad_out, pad_oe, pull_en, pull_up, fn_in, fn_sel);
    modport ball(input ctrl, hold_off, fn_out, fn_oe, pad_in,
        output pad_out, pad_oe, pull_en, pull_up, fn_in, fn_sel);
endinterface
`default_nettype wire

/* rtl/bfm_ball.sv */
/*
 * Routing for one ball: picks the function named by the mode code,
 * applies overrides and pulls, registers everything toward the pad.
 * Assumes the control word is stable register state.
 */
`timescale 1ns/1ps
`default_nettype none
module bfm_ball #(
    parameter logic [bfm_pkg::NMODE-1:0] VALID = 16'h0001,
    parameter logic [bfm_pkg::NMODE-1:0] OUTM = 16'h0001,
    parameter bit HASPULL = 1'b1,
    parameter bit ODRAIN = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // ball carrier
    bfm_ball_if.ball bi
);
    // mode decode
    wire [bfm_pkg::MODE_W-1:0] sel =
        bi.ctrl[bfm_pkg::FSEL_MSB:bfm_pkg::FSEL_LSB];
    wire listed = VALID[sel];
    wire drv_out = listed & bi.fn_out[sel];
    wire drv_oe = listed & OUTM[sel] & bi.fn_oe[sel];
    wire oe_ctl = bi.ctrl[bfm_pkg::OE_CTRL_BIT];
    wire oe_raw = bi.hold_off ? 1'b0 :
        (oe_ctl ? ~bi.ctrl[bfm_pkg::OE_OVR_BIT] : drv_oe);
    // open drain only ever pulls low
    wire out_nxt = ODRAIN ? 1'b0 : drv_out;
    wire oe_nxt = ODRAIN ? (oe_raw & ~drv_out) : oe_raw;
    wire in_nxt = bi.ctrl[bfm_pkg::IE_CTRL_BIT] ?
        bi.ctrl[bfm_pkg::IE_OVR_BIT] : bi.pad_in;
    wire pen_nxt = HASPULL & ~bi.ctrl[bfm_pkg::PULL_DIS_BIT];
    wire [bfm_pkg::NMODE-1:0] onehot = {{(bfm_pkg::NMODE-1){1'b0}}, 1'b1};
    wire [bfm_pkg::NMODE-1:0] sel_nxt = listed ? (onehot << sel) :
        {bfm_pkg::NMODE{1'b0}};

    // pad side registers; a cycle of latency keeps pads glitch free
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bi.pad_out <= 1'b0;
            bi.pad_oe <= 1'b0;
            bi.pull_en <= 1'b0;
            bi.pull_up <= 1'b0;
            bi.fn_in <= 1'b0;
            bi.fn_sel <= {bfm_pkg::NMODE{1'b0}};
        end else if (ce) begin
            bi.pad_out <= out_nxt;
            bi.pad_oe <= oe_nxt;
            bi.pull_en <= pen_nxt;
            bi.pull_up <= bi.ctrl[bfm_pkg::PULL_UP_BIT];
            bi.fn_in <= in_nxt;
            bi.fn_sel <= sel_nxt;
        end
    end
endmodule
`default_nettype wire

/* rtl/bfm_top.sv */
/*
 * Ball function multiplexer for ten balls: control registers on the
 * processor register port, per-ball routing, boot strap capture.
 * Assumes synchronous pad inputs and a register port that presents
 * a full byte address with one-cycle read and write strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module bfm_top (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // register port
    input wire logic [31:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [bfm_pkg::REG_W-1:0] reg_wdata,
    input wire logic reg_rd,
    output logic [bfm_pkg::REG_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_err,
    // balls
    input wire logic [bfm_pkg::NBALL-1:0] pad_in,
    output logic [bfm_pkg::NBALL-1:0] pad_out,
    output logic [bfm_pkg::NBALL-1:0] pad_oe,
    output logic [bfm_pkg::NBALL-1:0] pull_en,
    output logic [bfm_pkg::NBALL-1:0] pull_up,
    // internal functions, per ball and per mode
    input wire logic [bfm_pkg::NBALL-1:0][bfm_pkg::NMODE-1:0] fn_out,
    input wire logic [bfm_pkg::NBALL-1:0][bfm_pkg::NMODE-1:0] fn_oe,
    output logic [bfm_pkg::NBALL-1:0] fn_in,
    output logic [bfm_pkg::NBALL-1:0][bfm_pkg::NMODE-1:0] fn_sel,
    // boot straps
    output logic boot_strap_bit0,
    output logic boot_strap_bit1,
    output logic strap_valid
);
    localparam int NB = bfm_pkg::NBALL;
    localparam int RW = bfm_pkg::REG_W;

    // register state and decode
    logic [RW-1:0] ctrl_r [NB];         // one control word per ball
    logic [NB-1:0] hit;                 // address match per ball
    logic [RW-1:0] rd_part [NB];        // gated read word per ball
    logic [RW-1:0] rd_acc [NB+1];       // or-chain of read words
    logic [bfm_pkg::MODE_W-1:0] sel_w [NB];
    logic [NB-1:0] listed_w;            // selected mode is listed
    logic [NB-1:0] exp_out;             // helper: expected pad level
    logic [NB-1:0] hold_w;              // output held for strap
    wire any_hit = |hit;

    // read response and strap state
    logic [RW-1:0] rdata_r;
    logic rvalid_r;
    logic err_r;
    logic strap_done_r;
    logic strap0_r;
    logic strap1_r;

    assign rd_acc[0] = {RW{1'b0}};

    genvar b;
    generate
        for (b = 0; b < NB; b++) begin : g_ball
            bfm_ball_if u_if();

            // full address compare, one word per ball
            assign hit[b] = (reg_addr == bfm_pkg::BALL_ADDR[b]);
            assign rd_part[b] = hit[b] ? ctrl_r[b] : {RW{1'b0}};
            assign rd_acc[b+1] = rd_acc[b] | rd_part[b];
            assign sel_w[b] =
                ctrl_r[b][bfm_pkg::FSEL_MSB:bfm_pkg::FSEL_LSB];
            // per-ball mode tables
            assign listed_w[b] = bfm_pkg::VALID_MASK[b][sel_w[b]];
            assign exp_out[b] = listed_w[b] & fn_out[b][sel_w[b]];
            // strap balls stay off until the strap is taken
            assign hold_w[b] = !strap_done_r &&
                (b == bfm_pkg::B_SYNC_OUT || b == bfm_pkg::B_TEST_DO);

            // control word: write stores the whole word
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    ctrl_r[b] <= bfm_pkg::RST_VAL[b];
                end else if (ce && reg_wr && hit[b]) begin
                    ctrl_r[b] <= reg_wdata;
                end
            end

            // carrier toward the ball logic
            assign u_if.ctrl = ctrl_r[b];
            assign u_if.hold_off = hold_w[b];
            assign u_if.fn_out = fn_out[b];
            assign u_if.fn_oe = fn_oe[b];
            assign u_if.pad_in = pad_in[b];
            assign pad_out[b] = u_if.pad_out;
            assign pad_oe[b] = u_if.pad_oe;
            assign pull_en[b] = u_if.pull_en;
            assign pull_up[b] = u_if.pull_up;
            assign fn_in[b] = u_if.fn_in;
            assign fn_sel[b] = u_if.fn_sel;

            // one routing slice per ball
            bfm_ball #(
                .VALID(bfm_pkg::VALID_MASK[b]),
                .OUTM(bfm_pkg::OUT_MASK[b]),
                .HASPULL(bfm_pkg::HAS_PULL[b]),
                .ODRAIN(bfm_pkg::OPEN_DRAIN[b])
            ) u_ball (
                .clk(clk),
                .rstn(rstn),
                .ce(ce),
                .bi(u_if.ball)
            );
        end
    endgenerate

    // read port: data registered, unmapped reads give zero and err
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= {RW{1'b0}};
            rvalid_r <= 1'b0;
            err_r <= 1'b0;
        end else if (ce) begin
            rdata_r <= reg_rd ? rd_acc[NB] : {RW{1'b0}};
            rvalid_r <= reg_rd;
            err_r <= (reg_rd || reg_wr) && !any_hit;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign reg_err = err_r;

    // straps are taken on the first enabled edge after reset release;
    // the level is never loaded under reset, only by the clock
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_done_r <= 1'b0;
            strap0_r <= 1'b0;
            strap1_r <= 1'b0;
        end else if (ce && !strap_done_r) begin
            strap_done_r <= 1'b1;
            strap0_r <= pad_in[bfm_pkg::B_TEST_DO];
            strap1_r <= pad_in[bfm_pkg::B_SYNC_OUT];
        end
    end

    assign boot_strap_bit0 = strap0_r;
    assign boot_strap_bit1 = strap1_r;
    assign strap_valid = strap_done_r;

    // checks, all on the single clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // strap capture as two steps: waiting, then taken
    sequence s_strap_wait;
        !strap_done_r && ce;
    endsequence
    sequence s_strap_taken;
        strap_done_r;
    endsequence

    a_strap_bit0: assert property (s_strap_wait |=>
        s_strap_taken ##0
        (boot_strap_bit0 == $past(pad_in[bfm_pkg::B_TEST_DO])))
        else $error("strap bit 0 not taken from test data out ball");
    a_strap_bit1: assert property (s_strap_wait |=>
        s_strap_taken ##0
        (boot_strap_bit1 == $past(pad_in[bfm_pkg::B_SYNC_OUT])))
        else $error("strap bit 1 not taken from sync output ball");
    a_strap_hold_off: assert property (!strap_done_r |=>
        !pad_oe[bfm_pkg::B_SYNC_OUT] && !pad_oe[bfm_pkg::B_TEST_DO])
        else $error("strap ball driven while strap sampled");
    a_strap_stays: assert property (strap_done_r |=>
        $stable(boot_strap_bit0) && $stable(boot_strap_bit1))
        else $error("strap value changed after capture");
    // a high function level must release the drain, never drive it
    a_warm_open_drain: assert property (ce
        && listed_w[bfm_pkg::B_WARM_RST]
        && fn_out[bfm_pkg::B_WARM_RST][sel_w[bfm_pkg::B_WARM_RST]]
        |=> !pad_out[bfm_pkg::B_WARM_RST] && !pad_oe[bfm_pkg::B_WARM_RST])
        else $error("warm reset ball not open drain");
    a_reset_tdo_on: assert property (strap_done_r && ce
        && ctrl_r[bfm_pkg::B_TEST_DO] == bfm_pkg::RST_VAL[bfm_pkg::B_TEST_DO]
        |=> pad_oe[bfm_pkg::B_TEST_DO])
        else $error("test data out ball not enabled after reset");
    a_unmapped_err: assert property (ce && reg_rd && !any_hit |=>
        reg_err && reg_rvalid && reg_rdata == 32'h00000000)
        else $error("unmapped read not answered with zero");

    generate
        for (b = 0; b < NB; b++) begin : g_chk
            a_read_back_word: assert property (ce && reg_rd
                && hit[b] |=> reg_rvalid && reg_rdata == $past(ctrl_r[b]))
                else $error("register read does not return ball word");
            a_fsel_write: assert property (ce && reg_wr && hit[b]
                |=> sel_w[b] ==
                $past(reg_wdata[bfm_pkg::FSEL_MSB:bfm_pkg::FSEL_LSB]))
                else $error("mode code not in low four bits");
            a_route_out: assert property (ce && listed_w[b]
                && !bfm_pkg::OPEN_DRAIN[b] |=> pad_out[b] == $past(exp_out[b]))
                else $error("ball does not carry selected function");
            a_mode_zero_sel: assert property (ce
                && sel_w[b] == bfm_pkg::MODE_DEFAULT
                |=> fn_sel[b] == 16'h0001)
                else $error("mode zero does not pick default signal");
            a_unlisted_quiet: assert property (ce && !listed_w[b]
                && !ctrl_r[b][bfm_pkg::OE_CTRL_BIT]
                |=> fn_sel[b] == 16'h0000 && !pad_oe[b] && !pad_out[b])
                else $error("unlisted mode still drives the ball");
            a_pull_gate: assert property (ce |=> pull_en[b] ==
                ($past(ctrl_r[b][bfm_pkg::PULL_DIS_BIT]) == 1'b0
                && bfm_pkg::HAS_PULL[b]))
                else $error("pull enable does not follow register");
            a_no_pull_ball: assert property (
                !bfm_pkg::HAS_PULL[b] |-> !pull_en[b])
                else $error("pull enabled on ball without pull");
            a_reset_fsel: assert property (
                $rose(strap_done_r) && !$past(reg_wr)
                |-> $past(sel_w[b]) == bfm_pkg::FSEL_RST)
                else $error("function select not one after reset");
        end
    endgenerate
endmodule
`default_nettype wire

/* sim/bfm_top_tb.sv */
/*
 * Self-checking bench for the ball function multiplexer top.
 * Assumes the register port answers one edge after a strobe and the
 * ball outputs follow the control words one enabled edge later.
 */
`timescale 1ns/1ps
`default_nettype none
module bfm_top_tb;
    // one row per ball: address, listed modes, modes able to drive
    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] listed;
        logic [15:0] drives;
    } bfm_row_t;
    localparam bfm_row_t ROWS [10] = '{
        '{32'hFFFFEA20, 16'h0047, 16'h0047},
        '{32'hFFFFEA1C, 16'h0007, 16'h0007},
        '{32'hFFFFEA00, 16'h0047, 16'h0047},
        '{32'hFFFFEA6C, 16'h02C3, 16'h0241},
        '{32'hFFFFEA70, 16'h0E03, 16'h0C03},
        '{32'hFFFFEA50, 16'h0107, 16'h0105},
        '{32'h0FFFEA58, 16'h0007, 16'h0001},
        '{32'hFFFFEA5C, 16'h02C7, 16'h00C7},
        '{32'hFFFFEA54, 16'h0047, 16'h0005},
        '{32'hFFFFEA48, 16'h0001, 16'h0001}};
    // power-on words: select one, output off unless listed enabled
    localparam logic [31:0] RST_WORD [10] = '{
        32'h000002C1, 32'h000002C1, 32'h000000C1, 32'h000000C1, 32'h000000C1,
        32'h000000C1, 32'h000002C1, 32'h00000141, 32'h000000C1, 32'h000001C1};
    localparam logic [9:0] PULLED = 10'h17F; // balls fitted with a pull
    localparam logic [15:0] FN_PAT = 16'hAAAA; // odd modes drive high
    // design connections
    logic clk, rstn, ce, reg_wr, reg_rd, reg_rvalid, reg_err;
    logic [31:0] reg_addr, reg_wdata, reg_rdata;
    logic [9:0] pad_in, pad_out, pad_oe, pull_en, pull_up, fn_in;
    logic [9:0][15:0] fn_out, fn_oe, fn_sel;
    logic boot_strap_bit0, boot_strap_bit1, strap_valid;
    int bad_count, tests_run;
    logic [31:0] rd_word, w;
    logic rv, er, eo;
    bfm_top DUT (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_err(reg_err),
        .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pull_en(pull_en), .pull_up(pull_up), .fn_out(fn_out),
        .fn_oe(fn_oe), .fn_in(fn_in), .fn_sel(fn_sel),
        .boot_strap_bit0(boot_strap_bit0), .boot_strap_bit1(boot_strap_bit1),
        .strap_valid(strap_valid));
    // 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // compare and count; unknowns never match
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // single exit point of the run
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // write strobe for one cycle; returns after the pads have followed
    task automatic write_reg(input logic [31:0] a, input logic [31:0] d,
        output logic e);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        e = reg_err;
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    // read strobe for one cycle; answer sampled in the cycle it stands
    task automatic read_reg(input logic [31:0] a, output logic [31:0] d,
        output logic v, output logic e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        d = reg_rdata;
        v = reg_rvalid;
        e = reg_err;
        reg_rd = 1'b0;
    endtask
    // reset pulse, then power-on state and strap capture
    task automatic do_reset(input logic s0, input logic s1);
        @(negedge clk);
        rstn = 1'b0;
        pad_in = {2'h0, s0, 2'h0, s1, 4'h0};
        repeat (16) @(negedge clk);
        check("oe in reset", pad_oe, 32'h0);
        check("valid in reset", strap_valid, 1'b0);
        rstn = 1'b1;
        @(negedge clk);
        check("strap0", boot_strap_bit0, s0);
        check("strap1", boot_strap_bit1, s1);
        check("strap valid", strap_valid, 1'b1);
        for (int b = 0; b < 10; b++) begin
            read_reg(ROWS[b].addr, rd_word, rv, er);
            check("reset word", rd_word, RST_WORD[b]);
            check("reset rvalid", rv, 1'b1);
        end
        check("reset oe", pad_oe, 10'h080);
        check("reset pull", pull_en, PULLED);
        check("reset up", pull_up, 10'h043);
    endtask
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
    // main sequence
    initial begin
        bad_count = 0;
        tests_run = 0;
        rstn = 1'b0;
        ce = 1'b1;
        reg_addr = 32'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        pad_in = 10'h0;
        fn_out = {10{FN_PAT}};
        fn_oe = '1;
        do_reset(1'b1, 1'b0);
        // every code on every ball, pull bits follow the code
        for (int b = 0; b < 10; b++) begin
            for (int m = 0; m < 16; m++) begin
                w = {22'h0, m[0], m[1], 4'h0, m[3:0]};
                pad_in = {10{m[2]}};
                write_reg(ROWS[b].addr, w, er);
                check("wr err", er, 1'b0);
                check("fn_sel", fn_sel[b],
                    ROWS[b].listed[m] ? 32'h1 << m : 32'h0);
                eo = ROWS[b].listed[m] & ROWS[b].drives[m]
                    & (b != 9 || !FN_PAT[m]);
                check("pad_oe", pad_oe[b], eo);
                if (b == 9) begin
                    check("drain out", pad_out[9], 1'b0);
                end else if (eo) begin
                    check("pad_out", pad_out[b], FN_PAT[m]);
                end
                check("pull_en", pull_en[b], PULLED[b] & ~m[1]);
                if (PULLED[b] && !m[1]) begin
                    check("pull_up", pull_up[b], m[0]);
                end
                check("fn_in", fn_in[b], m[2]);
                read_reg(ROWS[b].addr, rd_word, rv, er);
                check("readback", rd_word, w);
            end
        end
        // function enable low, then output override on and off
        fn_oe[0][1] = 1'b0;
        write_reg(ROWS[0].addr, 32'h00000001, er);
        check("fn oe off", pad_oe[0], 1'b0);
        write_reg(ROWS[0].addr, 32'h00000041, er);
        check("forced on", pad_oe[0], 1'b1);
        fn_oe[0][1] = 1'b1;
        write_reg(ROWS[0].addr, 32'h000000C1, er);
        check("forced off", pad_oe[0], 1'b0);
        // input override, and open drain released by a high level
        pad_in = 10'h0;
        fn_out[9][0] = 1'b1;
        // warm reset ball back to its listed mode, function level high
        write_reg(ROWS[9].addr, 32'h00000000, er);
        write_reg(ROWS[0].addr, 32'h00000031, er);
        check("ie forced", fn_in[0], 1'b1);
        check("drain high", pad_oe[9], 1'b0);
        // the all-ones upper byte form is not ball 6's address
        write_reg(32'hFFFFEA58, 32'h00000002, er);
        check("unmapped wr err", er, 1'b1);
        read_reg(32'hFFFFEA4C, rd_word, rv, er);
        check("unmapped rd", rd_word, 32'h0);
        check("unmapped rd err", er, 1'b1);
        read_reg(ROWS[6].addr, rd_word, rv, er);
        check("ball6 kept", rd_word, 32'h0000030F);
        // write and read in one cycle: read gives the old word
        @(negedge clk);
        reg_addr = ROWS[0].addr;
        reg_wdata = 32'h00000002;
        reg_wr = 1'b1;
        reg_rd = 1'b1;
        @(negedge clk);
        check("rd beside wr", reg_rdata, 32'h00000031);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        read_reg(ROWS[0].addr, rd_word, rv, er);
        check("new word", rd_word, 32'h00000002);
        // clock enable low freezes the register port
        ce = 1'b0;
        write_reg(ROWS[0].addr, 32'h00000006, er);
        ce = 1'b1;
        read_reg(ROWS[0].addr, rd_word, rv, er);
        check("frozen word", rd_word, 32'h00000002);
        // second reset in mid-run with the straps reversed
        do_reset(1'b0, 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
